// File: hdl/cpu_ctrl_pkg.sv
// Constants and types shared by the CPU status and cycle control slice.
// Notes on behaviour
// - Status word holds exactly five flags: sign, carry, zero, overflow, interrupt bit.
// - Sign flag takes the inverse of accumulator bit 7 after any operation but load changes it.
// - Addition puts the carry out of bit 7 into the carry flag.
// - Zero flag set on an all-zero ALU result, cleared otherwise.
// - After arithmetic, overflow is carry out of bit 6 xor bit 7.
// - Interrupt requests are honoured only while the interrupt bit is one.
// - Five system control outputs tell companion chips the current operation.
// - Power-up or external reset release clears the program counter to zero.
// - The same reset clears the interrupt control bit.
// - While external reset is held low the device idles and executes nothing.
// - Write strobe is high for one phase period ending every instruction cycle.
// - Instruction cycles last 4 or 6 phase periods, chosen per instruction.
// - All external data and address traffic uses the eight shared data lines.
// - Addresses cross the bus only for operand bytes, counter moves, vector push.
// - Two on-chip I/O ports talk to the accumulator without the data bus.
// - Interrupt-control pin is low when responding, high when ignoring requests.
// - Scratchpad register 9 is the save location for the status word.
package cpu_ctrl_pkg;
    // Register byte offsets on the Wishbone slave
    localparam logic [5:0] OFF_COMMAND = 6'h00;
    localparam logic [5:0] OFF_ACC = 6'h04;
    localparam logic [5:0] OFF_STATUS = 6'h08;
    localparam logic [5:0] OFF_SCRATCH_J = 6'h0C;
    localparam logic [5:0] OFF_PC = 6'h10;
    localparam logic [5:0] OFF_STATE = 6'h14;
    localparam logic [5:0] OFF_PORT0 = 6'h18;
    localparam logic [5:0] OFF_PORT1 = 6'h1C;
    localparam logic [5:0] OFF_IRQ_STATUS = 6'h20;
    localparam logic [5:0] OFF_IRQ_MASK = 6'h24;
    // Status flag positions
    localparam int FLAG_SIGN = 0;
    localparam int FLAG_CARRY = 1;
    localparam int FLAG_ZERO = 2;
    localparam int FLAG_OVF = 3;
    localparam int FLAG_ICB = 4;
    localparam int FLAG_COUNT = 5;
    localparam logic [4:0] STATUS_RESET = 5'h00;
    // Command register fields
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_LONG_BIT = 4;
    localparam int CMD_CTRL_LSB = 8;
    localparam int CMD_IMM_LSB = 16;
    // Interrupt event positions
    localparam int EV_CYCLE_DONE = 0;
    localparam int EV_INT_TAKEN = 1;
    localparam int EV_OVERFLOW = 2;
    localparam int EV_COUNT = 3;
    // Cycle lengths in phase periods; one phase period is one clock
    localparam logic [2:0] SHORT_PERIODS = 3'h4;
    localparam logic [2:0] LONG_PERIODS = 3'h6;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    typedef enum logic [3:0] {
        OP_ADD = 4'h0, OP_AND = 4'h1, OP_OR = 4'h2, OP_XOR = 4'h3,
        OP_INC = 4'h4, OP_CLR = 4'h5, OP_LOAD = 4'h6, OP_SAVE_W = 4'h7,
        OP_REST_W = 4'h8, OP_IN0 = 4'h9, OP_IN1 = 4'hA, OP_OUT0 = 4'hB,
        OP_OUT1 = 4'hC, OP_ICB_ON = 4'hD, OP_ADDR_IN = 4'hE,
        OP_ADDR_OUT = 4'hF
    } op_t;
    typedef enum logic [2:0] {
        ST_HOLD = 3'b001,
        ST_READY = 3'b010,
        ST_EXEC = 3'b100
    } cycle_state_t;
endpackage

// File: hdl/cpu_status_flags_cycle_ctrl.sv
// Status flags, instruction cycle timing and control outputs of the CPU core.
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module cpu_status_flags_cycle_ctrl (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic external_reset_input_n,
    input wire logic int_req_n,
    output logic interrupt_control_n,
    output logic write_strobe,
    output logic [4:0] system_control_outputs,
    input wire logic [7:0] data_bus_in,
    output logic [7:0] data_bus_out,
    output logic data_bus_oe_n,
    input wire logic [7:0] port0_in,
    output logic [7:0] port0_out,
    input wire logic [7:0] port1_in,
    output logic [7:0] port1_out,
    output logic irq
);
    import cpu_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [FLAG_COUNT-1:0] status_flags;
    logic [7:0] acc;
    logic [7:0] scratch_j;
    logic [15:0] program_counter_main;
    logic [EV_COUNT-1:0] irq_status;
    logic [EV_COUNT-1:0] irq_mask;
    cycle_state_t state;
    logic [2:0] period;
    logic [2:0] last_period;
    op_t op;
    logic [7:0] imm;
    logic [7:0] addr_hi;
    logic bus_access;
    logic bus_write;
    logic bus_read;
    logic ext_reset_q;
    logic start;
    logic finish;
    logic take_int;
    logic [8:0] sum9;
    logic [7:0] low7_sum;
    logic [7:0] alu_b;
    logic [7:0] next_acc;
    logic [FLAG_COUNT-1:0] next_flags;
    logic [EV_COUNT-1:0] events;
    logic [31:0] next_rdata;

    // Bus decode; the request is served in the edge where ack rises
    assign bus_access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign bus_write = bus_access & wb_we_i & wb_sel_i[0];
    assign bus_read = bus_access & ~wb_we_i;
    // A command is ignored unless the cycle engine is ready
    assign start = bus_write && wb_adr_i == OFF_COMMAND &&
                   state == ST_READY;
    assign finish = state == ST_EXEC && period == last_period;
    assign take_int = state == ST_READY && ~int_req_n &&
                      status_flags[FLAG_ICB];

    ////////////////////////////////////////////////////////////////////////
    // ALU datapath and flag generation
    assign alu_b = (op == OP_INC) ? 8'h01 : imm;
    assign sum9 = {1'b0, acc} + {1'b0, alu_b};
    assign low7_sum = {1'b0, acc[6:0]} + {1'b0, alu_b[6:0]};

    always_comb begin
        next_acc = acc;
        next_flags = status_flags;
        case (op)
            OP_ADD, OP_INC: begin
                next_acc = sum9[7:0];
                next_flags[FLAG_CARRY] = sum9[8];
                next_flags[FLAG_OVF] = sum9[8] ^ low7_sum[7];
            end
            OP_AND: begin
                next_acc = acc & imm;
                next_flags[FLAG_CARRY] = 1'b0;
                next_flags[FLAG_OVF] = 1'b0;
            end
            OP_OR: begin
                next_acc = acc | imm;
                next_flags[FLAG_CARRY] = 1'b0;
                next_flags[FLAG_OVF] = 1'b0;
            end
            OP_XOR: begin
                next_acc = acc ^ imm;
                next_flags[FLAG_CARRY] = 1'b0;
                next_flags[FLAG_OVF] = 1'b0;
            end
            OP_CLR: next_acc = BYTE_ZERO;
            OP_LOAD: next_acc = imm;
            OP_IN0: next_acc = port0_in;
            OP_IN1: next_acc = port1_in;
            OP_REST_W: next_flags = scratch_j[FLAG_COUNT-1:0];
            OP_ICB_ON: next_flags[FLAG_ICB] = imm[0];
            default: next_acc = acc;
        endcase
        // Sign and zero follow any operation except OP_LOAD that rewrites the accumulator
        case (op)
            OP_ADD, OP_INC, OP_AND, OP_OR, OP_XOR, OP_CLR, OP_IN0,
            OP_IN1: begin
                next_flags[FLAG_SIGN] = ~next_acc[7];
                next_flags[FLAG_ZERO] = next_acc == BYTE_ZERO;
            end
            default: next_flags[FLAG_SIGN] = next_flags[FLAG_SIGN];
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // External reset pin, taken as synchronous and registered once
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ext_reset_q <= 1'b0;
        end else begin
            ext_reset_q <= external_reset_input_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Cycle engine: hold while reset pin low, else ready or executing
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= ST_HOLD;
            period <= 3'h0;
            last_period <= SHORT_PERIODS - 3'h1;
            op <= OP_LOAD;
            imm <= BYTE_ZERO;
        end else begin
            case (state)
                ST_HOLD: begin
                    if (ext_reset_q) begin
                        state <= ST_READY;
                    end
                end
                ST_READY: begin
                    if (!ext_reset_q) begin
                        state <= ST_HOLD;
                    end else if (start) begin
                        state <= ST_EXEC;
                        period <= 3'h0;
                        op <= op_t'(wb_dat_i[CMD_OP_LSB +: 4]);
                        imm <= wb_dat_i[CMD_IMM_LSB +: 8];
                        // Cycle length is picked per instruction
                        last_period <= wb_dat_i[CMD_LONG_BIT] ?
                            LONG_PERIODS - 3'h1 :
                            SHORT_PERIODS - 3'h1;
                    end
                end
                ST_EXEC: begin
                    if (!ext_reset_q) begin
                        state <= ST_HOLD;
                    end else if (finish) begin
                        state <= ST_READY;
                    end else begin
                        period <= period + 3'h1;
                    end
                end
                default: state <= ST_HOLD;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Strobe and control code; strobe occupies the last phase period
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            write_strobe <= 1'b0;
            system_control_outputs <= 5'h00;
        end else begin
            write_strobe <= state == ST_EXEC && ext_reset_q &&
                            period == last_period - 3'h1;
            if (start) begin
                // Held for the whole machine cycle
                system_control_outputs <=
                    wb_dat_i[CMD_CTRL_LSB +: 5];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared data bus: address bytes only for the permitted transfers
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            data_bus_out <= BYTE_ZERO;
            data_bus_oe_n <= 1'b1;
            addr_hi <= BYTE_ZERO;
        end else begin
            data_bus_oe_n <= 1'b1;
            if (state == ST_EXEC && op == OP_ADDR_OUT) begin
                // Counter-to-scratchpad move: high byte, then low
                data_bus_oe_n <= 1'b0;
                data_bus_out <= (period == 3'h0) ?
                    program_counter_main[15:8] :
                    program_counter_main[7:0];
            end
            if (state == ST_EXEC && op == OP_ADDR_IN && period == 3'h1) begin
                addr_hi <= data_bus_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Program counter: cleared by any reset, stepped per instruction
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            program_counter_main <= PC_RESET;
        end else if (!ext_reset_q) begin
            program_counter_main <= PC_RESET;
        end else if (finish && op == OP_ADDR_IN) begin
            // Operand bytes two and three form the new address
            program_counter_main <= {addr_hi, data_bus_in};
        end else if (finish) begin
            program_counter_main <= program_counter_main + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Accumulator, status word, save register and port latches
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            acc <= BYTE_ZERO;
            status_flags <= STATUS_RESET;
            scratch_j <= BYTE_ZERO;
            port0_out <= BYTE_ZERO;
            port1_out <= BYTE_ZERO;
        end else if (!ext_reset_q) begin
            // Only the interrupt bit is forced; data survives the pin
            status_flags[FLAG_ICB] <= 1'b0;
        end else if (finish) begin
            acc <= next_acc;
            status_flags <= next_flags;
            if (op == OP_SAVE_W) begin
                scratch_j <= {3'h0, status_flags};
            end
            if (op == OP_OUT0) begin
                port0_out <= acc;
            end
            if (op == OP_OUT1) begin
                port1_out <= acc;
            end
        end else if (state == ST_READY && bus_write) begin
            // Software access only between instructions
            if (wb_adr_i == OFF_ACC) begin
                acc <= wb_dat_i[7:0];
            end
            if (wb_adr_i == OFF_STATUS) begin
                status_flags <= wb_dat_i[FLAG_COUNT-1:0];
            end
            if (wb_adr_i == OFF_PORT0) begin
                port0_out <= wb_dat_i[7:0];
            end
            if (wb_adr_i == OFF_PORT1) begin
                port1_out <= wb_dat_i[7:0];
            end
        end
    end

    // Pin is the inverse of the enable flag, low while listening
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            interrupt_control_n <= 1'b1;
        end else begin
            interrupt_control_n <= ~status_flags[FLAG_ICB];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status: sticky, cleared by read, a new event wins
    assign events[EV_CYCLE_DONE] = finish;
    assign events[EV_INT_TAKEN] = take_int;
    assign events[EV_OVERFLOW] = finish && next_flags[FLAG_OVF] &&
                                 (op == OP_ADD || op == OP_INC);

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq_status <= 3'h0;
            irq_mask <= 3'h0;
        end else begin
            if (bus_read && wb_adr_i == OFF_IRQ_STATUS) begin
                irq_status <= events;
            end else begin
                irq_status <= irq_status | events;
            end
            if (bus_write && wb_adr_i == OFF_IRQ_MASK) begin
                irq_mask <= wb_dat_i[EV_COUNT-1:0];
            end
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped addresses read zero and are still acknowledged
    always_comb begin
        next_rdata = 32'h0000_0000;
        case (wb_adr_i)
            OFF_ACC: next_rdata[7:0] = acc;
            OFF_STATUS: next_rdata[FLAG_COUNT-1:0] = status_flags;
            OFF_SCRATCH_J: next_rdata[7:0] = scratch_j;
            OFF_PC: next_rdata[15:0] = program_counter_main;
            OFF_STATE: next_rdata[2:0] = state;
            OFF_PORT0: next_rdata[7:0] = port0_in;
            OFF_PORT1: next_rdata[7:0] = port1_in;
            OFF_IRQ_STATUS: next_rdata[EV_COUNT-1:0] = irq_status;
            OFF_IRQ_MASK: next_rdata[EV_COUNT-1:0] = irq_mask;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_access;
            if (bus_read) begin
                wb_dat_o <= next_rdata;
            end
        end
    end
endmodule

// File: bench/cpu_ctrl_properties.sv
// Port checker for the CPU status and cycle control slice.
`timescale 1ns/1ps
module cpu_ctrl_properties (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_ack_o,
    input wire logic external_reset_input_n,
    input wire logic interrupt_control_n,
    input wire logic write_strobe,
    input wire logic [4:0] system_control_outputs,
    input wire logic data_bus_oe_n
);
    import cpu_ctrl_pkg::*;
    logic cmd_req;
    logic [3:0] age;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    // Age of the last command; saturates so an idle bus never wraps it
    assign cmd_req = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
        && wb_sel_i[0] && wb_adr_i == OFF_COMMAND;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            age <= 4'hF;
        end else if (cmd_req) begin
            age <= 4'h0;
        end else if (age != 4'hF) begin
            age <= age + 4'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    sequence ext_held;
        !external_reset_input_n [*4];
    endsequence
    sequence strobe_end;
        $fell(write_strobe);
    endsequence
    a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_next_edge: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    a_strobe_one_period: assert property (
        $rose(write_strobe) |=> !write_strobe)
        else $error("write strobe not one period");
    a_cycle_length: assert property (
        $rose(write_strobe) |-> age == 4'h3 || age == 4'h5)
        else $error("instruction cycle neither short nor long");
    a_strobe_gap: assert property (strobe_end |-> !write_strobe [*3])
        else $error("strobes too close");
    a_idle_in_reset: assert property (ext_held |-> !write_strobe)
        else $error("cycle ended while held in reset");
    a_icb_pin_cleared: assert property (
        ext_held |-> interrupt_control_n)
        else $error("interrupt pin listening during reset");
    a_icb_pin_by_cmd: assert property (
        $fell(interrupt_control_n) |-> age <= 4'h7)
        else $error("interrupt pin enabled without command");
    a_bus_in_cycle: assert property (!data_bus_oe_n |-> age < 4'h8)
        else $error("data bus driven outside a cycle");
    a_ctrl_on_cmd: assert property (
        $changed(system_control_outputs) |-> age <= 4'h2)
        else $error("control outputs moved without command");
endmodule
bind cpu_status_flags_cycle_ctrl cpu_ctrl_properties u_cpu_ctrl_properties (
    .clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o),
    .external_reset_input_n(external_reset_input_n),
    .interrupt_control_n(interrupt_control_n),
    .write_strobe(write_strobe),
    .system_control_outputs(system_control_outputs),
    .data_bus_oe_n(data_bus_oe_n));

// File: bench/companion_bus_model.sv
// Companion memory interface model on the shared eight bit data bus.
`timescale 1ns/1ps
module companion_bus_model #(
    parameter logic [4:0] FETCH_CODE = 5'h1E
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] data_bus_out,
    input wire logic data_bus_oe_n,
    input wire logic write_strobe,
    input wire logic [4:0] system_control_outputs,
    input wire logic [15:0] serve_address,
    output logic [7:0] data_bus_wire,
    output logic [7:0] seen_high,
    output logic [7:0] seen_low
);
    logic [2:0] period;
    logic [7:0] last_byte;
    logic was_driving;
    logic fetch;
    // Wire level; idle bus shows a changing pattern, never a stale byte
    assign fetch = system_control_outputs == FETCH_CODE;
    assign data_bus_wire = !data_bus_oe_n ? data_bus_out :
        fetch ? (period < 3'h2 ? serve_address[15:8] :
        serve_address[7:0]) : ~last_byte;
    // Period within a fetch cycle, restarted by each strobe
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            period <= 3'h0;
            last_byte <= 8'h00;
        end else begin
            last_byte <= data_bus_wire;
            if (write_strobe) begin
                period <= 3'h0;
            end else if (fetch && period != 3'h7) begin
                period <= period + 3'h1;
            end
        end
    end
    // First driven byte is the high half, later ones the low half
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            was_driving <= 1'b0;
            seen_high <= 8'h00;
            seen_low <= 8'h00;
        end else begin
            was_driving <= !data_bus_oe_n;
            if (!data_bus_oe_n && !was_driving) begin
                seen_high <= data_bus_out;
            end else if (!data_bus_oe_n) begin
                seen_low <= data_bus_out;
            end
        end
    end
endmodule

// File: bench/tb_cpu_status_flags_cycle_ctrl.sv
// Self-checking bench for the CPU status and cycle control slice.
`timescale 1ns/1ps
module tb_cpu_status_flags_cycle_ctrl;
    import cpu_ctrl_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [5:0] wb_adr_i = 6'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic external_reset_input_n = 1'b1;
    logic int_req_n = 1'b1;
    logic interrupt_control_n;
    logic write_strobe;
    logic [4:0] system_control_outputs;
    logic [7:0] data_bus_wire;
    logic [7:0] data_bus_out;
    logic data_bus_oe_n;
    logic [7:0] port0_out;
    logic [7:0] port1_out;
    logic irq;
    logic [7:0] seen_high;
    logic [7:0] seen_low;
    logic [31:0] rd;
    logic bus_used = 1'b0;
    int len;
    int checks = 0;
    int n_mismatch = 0;
    logic [7:0] va [6] = '{8'h65, 8'h9D, 8'hB3, 8'h67, 8'h00, 8'h80};
    logic [7:0] vb [6] = '{8'h76, 8'hD1, 8'h71, 8'h24, 8'h00, 8'h80};
    cpu_status_flags_cycle_ctrl u_cpu_status_flags_cycle_ctrl (
        .clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .external_reset_input_n(external_reset_input_n),
        .int_req_n(int_req_n), .interrupt_control_n(interrupt_control_n),
        .write_strobe(write_strobe),
        .system_control_outputs(system_control_outputs),
        .data_bus_in(data_bus_wire), .data_bus_out(data_bus_out),
        .data_bus_oe_n(data_bus_oe_n), .port0_in(8'h5A),
        .port0_out(port0_out), .port1_in(8'hA7), .port1_out(port1_out),
        .irq(irq));
    companion_bus_model u_companion_bus_model (
        .clock(clock), .reset_n(reset_n), .data_bus_out(data_bus_out),
        .data_bus_oe_n(data_bus_oe_n), .write_strobe(write_strobe),
        .system_control_outputs(system_control_outputs),
        .serve_address(16'h1234), .data_bus_wire(data_bus_wire),
        .seen_high(seen_high), .seen_low(seen_low));
    // Free running clock; the bus flag notes any drive of the shared bus
    always #20 clock = ~clock;
    always @(posedge clock) if (data_bus_oe_n === 1'b0) bus_used <= 1'b1;
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One classic cycle; ack is taken at the edge it is sampled high
    task automatic wb(input logic we, input logic [5:0] adr,
        input logic [31:0] dat);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        @(posedge clock);
        while (wb_ack_o !== 1'b1) @(posedge clock);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clock);
    endtask
    // Command, then wait for the closing strobe to pass
    task automatic cmd(input op_t op, input logic lng, input logic [7:0] imm);
        wb(1'b1, OFF_COMMAND, {8'h00, imm, 4'h1, op, 3'h0, lng, op});
        len = 0;
        while (write_strobe !== 1'b1 && len < 20) begin
            len++;
            @(posedge clock);
        end
        check("control code", system_control_outputs, {1'b1, op});
        repeat (2) @(posedge clock);
    endtask
    function automatic logic [31:0] add_flags(input logic [7:0] a, b);
        logic [8:0] s;
        logic [7:0] low;
        s = {1'b0, a} + {1'b0, b};
        low = {1'b0, a[6:0]} + {1'b0, b[6:0]};
        return {28'h0, low[7] ^ s[8], s[7:0] == 8'h00, s[8], ~s[7]};
    endfunction
    task automatic give_verdict;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge clock);
        n_mismatch++;
        give_verdict;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (10) @(posedge clock);
        reset_n <= 1'b1;
        repeat (3) @(posedge clock);
        wb(1'b0, OFF_STATUS, 32'h0); check("status", rd, 32'h0);
        wb(1'b0, OFF_PC, 32'h0); check("pc", rd, 32'h0);
        for (int i = 0; i < 6; i++) begin
            cmd(OP_LOAD, 1'b0, va[i]);
            cmd(OP_ADD, i[0], vb[i]);
            check("len", len, (i[0] ? LONG_PERIODS : SHORT_PERIODS) - 3'h2);
            wb(1'b0, OFF_ACC, 32'h0); check("sum", rd, {24'h0, va[i] + vb[i]});
            wb(1'b0, OFF_STATUS, 32'h0); check("flags", rd, add_flags(va[i], vb[i]));
        end
        cmd(OP_LOAD, 1'b0, 8'h55);
        wb(1'b0, OFF_STATUS, 32'h0); check("kept", rd, 32'h0F);
        cmd(OP_AND, 1'b0, 8'h0F);
        wb(1'b0, OFF_STATUS, 32'h0); check("and", rd, 32'h01);
        cmd(OP_XOR, 1'b0, 8'h05);
        wb(1'b0, OFF_STATUS, 32'h0); check("xor", rd, 32'h05);
        cmd(OP_SAVE_W, 1'b0, 8'h00);
        wb(1'b0, OFF_SCRATCH_J, 32'h0); check("save", rd, 32'h05);
        cmd(OP_INC, 1'b0, 8'h00);
        wb(1'b0, OFF_STATUS, 32'h0); check("inc", rd, 32'h01);
        cmd(OP_REST_W, 1'b0, 8'h00);
        wb(1'b0, OFF_STATUS, 32'h0); check("restore", rd, 32'h05);
        bus_used <= 1'b0;
        cmd(OP_IN0, 1'b0, 8'h00);
        cmd(OP_OUT1, 1'b0, 8'h00);
        cmd(OP_IN1, 1'b0, 8'h00);
        wb(1'b0, OFF_STATUS, 32'h0); check("in", rd, 32'h00);
        cmd(OP_OUT0, 1'b0, 8'h00);
        check("port0", port0_out, 8'hA7);
        check("port1", port1_out, 8'h5A);
        check("bus idle", bus_used, 1'b0);
        wb(1'b0, OFF_IRQ_STATUS, 32'h0);
        int_req_n <= 1'b0;
        repeat (4) @(posedge clock);
        wb(1'b0, OFF_IRQ_STATUS, 32'h0); check("ignored", rd, 32'h0);
        check("pin off", interrupt_control_n, 1'b1);
        cmd(OP_ICB_ON, 1'b0, 8'h01);
        check("pin on", interrupt_control_n, 1'b0);
        wb(1'b1, OFF_IRQ_MASK, 32'h0);
        check("masked", irq, 1'b0);
        wb(1'b1, OFF_IRQ_MASK, 32'h0000_0002);
        check("irq", irq, 1'b1);
        int_req_n <= 1'b1;
        wb(1'b0, OFF_IRQ_STATUS, 32'h0); check("events", rd, 32'h3);
        check("cleared", irq, 1'b0);
        cmd(OP_ADDR_IN, 1'b1, 8'h00);
        wb(1'b0, OFF_PC, 32'h0); check("pc in", rd, 32'h1234);
        cmd(OP_ADDR_OUT, 1'b1, 8'h00);
        check("pc hi", seen_high, 8'h12);
        check("pc lo", seen_low, 8'h34);
        wb(1'b1, 6'h3C, 32'hFFFF_FFFF);
        wb(1'b0, OFF_STATUS, 32'h0); check("status", rd, 32'h10);
        external_reset_input_n <= 1'b0;
        repeat (5) @(posedge clock);
        wb(1'b1, OFF_COMMAND, {24'h0077_00, 8'h06});
        wb(1'b0, OFF_STATE, 32'h0); check("hold", rd, 32'h1);
        wb(1'b0, OFF_ACC, 32'h0); check("acc", rd, 32'hA7);
        wb(1'b0, OFF_PC, 32'h0); check("pc reset", rd, 32'h0);
        wb(1'b0, OFF_STATUS, 32'h0); check("icb", rd, 32'h0);
        external_reset_input_n <= 1'b1;
        repeat (4) @(posedge clock);
        wb(1'b0, OFF_STATE, 32'h0); check("ready", rd, 32'h2);
        give_verdict;
    end
endmodule
